/* File: core/irq_ctl_pkg.sv */
// Purpose: Shared constants and types for the interrupt controller
// Assumes: Registers are eight bits wide, one per aligned 32-bit bus word
// Notes:   Byte address of a register is its index times four
package irq_ctl_pkg;

    // Register map, byte address = index * 4
    localparam int          REG_CNT      = 8;
    localparam int          ADDR_W       = 5;
    localparam logic [2:0]  IDX_EDGE     = 3'h0;
    localparam logic [2:0]  IDX_CTL_A    = 3'h1;
    localparam logic [2:0]  IDX_CTL_B    = 3'h2;
    localparam logic [2:0]  IDX_CTL_C    = 3'h3;
    localparam logic [2:0]  IDX_GRP_A    = 3'h4;
    localparam logic [2:0]  IDX_GRP_B    = 3'h5;
    localparam logic [2:0]  IDX_GRP_C    = 3'h6;
    localparam logic [2:0]  IDX_GRP_D    = 3'h7;
    localparam logic [7:0]  REG_RESET    = 8'h00;

    // Implemented bits and request-flag bits of each register
    localparam logic [7:0] IMPL_MASK [REG_CNT] =
        '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33};
    localparam logic [7:0] FLAG_MASK [REG_CNT] =
        '{8'h00, 8'h70, 8'hF0, 8'hF0, 8'h30, 8'hF0, 8'h70, 8'h30};

    // Edge select fields and encodings
    localparam int          PIN0_SEL_LSB = 0;
    localparam int          PIN1_SEL_LSB = 2;
    localparam logic [1:0]  EDGE_OFF     = 2'h0;
    localparam logic [1:0]  EDGE_RISE    = 2'h1;
    localparam logic [1:0]  EDGE_FALL    = 2'h2;
    localparam logic [1:0]  EDGE_BOTH    = 2'h3;

    // Bit positions of the global enable and of hardware-set flags
    localparam int EMI_BIT   = 0;
    localparam int PIN0_BIT  = 4;
    localparam int PIN1_BIT  = 5;
    localparam int TOUCH_BIT = 6;
    localparam int UART_BIT  = 4;
    localparam int GRP0_BIT  = 5;
    localparam int GRP1_BIT  = 6;
    localparam int ADC_BIT   = 7;
    localparam int GRP2_BIT  = 4;
    localparam int TICK0_BIT = 5;
    localparam int TICK1_BIT = 6;
    localparam int GRP3_BIT  = 7;
    localparam int MATCH_P0  = 4;
    localparam int MATCH_A0  = 5;
    localparam int MATCH_P1  = 6;
    localparam int MATCH_A1  = 7;
    localparam int SIM_BIT   = 6;
    localparam int LVD_BIT   = 4;
    localparam int EEW_BIT   = 5;

    // Vectored sources, listed in priority order (index 0 highest)
    localparam int NUM_SRC = 11;
    localparam int SRC_W   = 4;
    localparam int SRC_REG  [NUM_SRC] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
    localparam int SRC_FLAG [NUM_SRC] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7};
    localparam int SRC_EN   [NUM_SRC] = '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3};

    // Event pulses from on-chip peripherals
    typedef struct packed {
        logic touch;
        logic uart;
        logic adc;
        logic tick0;
        logic tick1;
        logic ctimer0_match_a;
        logic ctimer0_match_p;
        logic ctimer1_match_a;
        logic ctimer1_match_p;
        logic stdtimer_match_a;
        logic stdtimer_match_p;
        logic periodic_timer_match_a;
        logic periodic_timer_match_p;
        logic serial_iface;
        logic eeprom_write;
        logic low_voltage;
    } periph_evt_s;

endpackage

/* File: core/irq_controller.sv */
// Purpose: Interrupt controller: flags, enables, priority, vector and stack
// Assumes: Pins and events synchronous to clk_sys; core asks at boundaries
// Notes:   Registers on Avalon-MM, one wait state on every access
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
module irq_controller
    import irq_ctl_pkg::*;
#(
    parameter int PC_W        = 13,
    parameter int STACK_DEPTH = 8,
    parameter int VEC_BASE    = 4,
    parameter int VEC_STEP    = 4
) (
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic [irq_ctl_pkg::ADDR_W-1:0] address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    input  wire logic                     ext_pin_zero,
    input  wire logic                     ext_pin_one,
    input  wire irq_ctl_pkg::periph_evt_s periph_evt,
    input  wire logic                     core_ready,
    input  wire logic [PC_W-1:0]          fetch_pc,
    input  wire logic                     return_from_interrupt,
    output logic                          irq_take,
    output logic                          pc_load_valid,
    output logic      [PC_W-1:0]          pc_load,
    output logic                          wake
);
    import irq_ctl_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam int IX_W = $clog2(STACK_DEPTH);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
    localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);

    logic              rst_meta;
    logic              rst_n;
    logic [7:0]        regs      [REG_CNT];
    logic [7:0]        next_regs [REG_CNT];
    logic [7:0]        sw_val    [REG_CNT];
    logic [7:0]        hw_set    [REG_CNT];
    logic [7:0]        hw_clr    [REG_CNT];
    logic [REG_CNT-1:0] wr_hit;
    logic [REG_CNT-1:0] flag_rise;
    logic [3:0]        grp_rise;
    logic              pin0_q;
    logic              pin1_q;
    logic              pin0_hit;
    logic              pin1_hit;
    logic [NUM_SRC-1:0] pend;
    logic [SRC_W-1:0]  sel;
    logic              take_now;
    logic              return_from_interrupt_now;
    logic              bus_wr;
    logic              bus_rd;
    logic [2:0]        reg_idx;
    logic              addr_ok;
    logic [PC_W-1:0]   stack_mem [STACK_DEPTH];
    logic [SP_W-1:0]   sp;
    logic [IX_W-1:0]   top_idx;
    logic [IX_W-1:0]   push_idx;
    logic [PC_W-1:0]   stack_top;
    logic [PC_W-1:0]   vector_pc;
    logic              global_irq_enable;

    // Reset: asserted at once, released through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Bus decode; a write lands on the edge where waitrequest is low, a read is latched one edge earlier
    assign reg_idx = address[ADDR_W-1:2];
    assign addr_ok = (address[1:0] == 2'h0);
    assign bus_wr  = write && !waitrequest && addr_ok;
    assign bus_rd  = read && waitrequest;

    // One wait state, then a single ready cycle per request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (bus_rd) begin
                readdata <= addr_ok ? {24'h00_0000, regs[reg_idx] & IMPL_MASK[reg_idx]}
                                    : 32'h0000_0000;
            end
        end
    end

    // External pin edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin0_q <= 1'b0;
            pin1_q <= 1'b0;
        end else begin
            pin0_q <= ext_pin_zero;
            pin1_q <= ext_pin_one;
        end
    end

    function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic old);
        logic rise;
        logic fall;
        rise = now && !old;
        fall = !now && old;
        edge_hit = ((mode == EDGE_RISE) && rise) || ((mode == EDGE_FALL) && fall) ||
                   ((mode == EDGE_BOTH) && (rise || fall));
    endfunction

    assign pin1_hit = edge_hit(regs[IDX_EDGE][PIN1_SEL_LSB +: 2], ext_pin_one, pin1_q);
    assign pin0_hit = edge_hit(regs[IDX_EDGE][PIN0_SEL_LSB +: 2], ext_pin_zero, pin0_q);

    generate
        for (genvar k = 0; k < 4; k++) begin : g_grp
            assign grp_rise[k] = |(next_regs[IDX_GRP_A + 3'(k)] & ~regs[IDX_GRP_A + 3'(k)]
                                   & FLAG_MASK[IDX_GRP_A + 3'(k)]);
        end
    endgenerate

    // Hardware set requests, independent of enables
    always_comb begin
        for (int r = 0; r < REG_CNT; r++) begin
            hw_set[r] = 8'h00;
        end
        hw_set[IDX_CTL_A][TOUCH_BIT] = periph_evt.touch;
        hw_set[IDX_CTL_A][PIN1_BIT]  = pin1_hit;
        hw_set[IDX_CTL_A][PIN0_BIT]  = pin0_hit;
        hw_set[IDX_CTL_B][ADC_BIT]   = periph_evt.adc;
        hw_set[IDX_CTL_B][GRP1_BIT]  = grp_rise[1];
        hw_set[IDX_CTL_B][GRP0_BIT]  = grp_rise[0];
        hw_set[IDX_CTL_B][UART_BIT]  = periph_evt.uart;
        hw_set[IDX_CTL_C][GRP3_BIT]  = grp_rise[3];
        hw_set[IDX_CTL_C][TICK1_BIT] = periph_evt.tick1;
        hw_set[IDX_CTL_C][TICK0_BIT] = periph_evt.tick0;
        hw_set[IDX_CTL_C][GRP2_BIT]  = grp_rise[2];
        hw_set[IDX_GRP_A][MATCH_A0]  = periph_evt.ctimer0_match_a;
        hw_set[IDX_GRP_A][MATCH_P0]  = periph_evt.ctimer0_match_p;
        hw_set[IDX_GRP_B][MATCH_A1]  = periph_evt.stdtimer_match_a;
        hw_set[IDX_GRP_B][MATCH_P1]  = periph_evt.stdtimer_match_p;
        hw_set[IDX_GRP_B][MATCH_A0]  = periph_evt.ctimer1_match_a;
        hw_set[IDX_GRP_B][MATCH_P0]  = periph_evt.ctimer1_match_p;
        hw_set[IDX_GRP_C][SIM_BIT]   = periph_evt.serial_iface;
        hw_set[IDX_GRP_C][MATCH_A0]  = periph_evt.periodic_timer_match_a;
        hw_set[IDX_GRP_C][MATCH_P0]  = periph_evt.periodic_timer_match_p;
        hw_set[IDX_GRP_D][EEW_BIT]   = periph_evt.eeprom_write;
        hw_set[IDX_GRP_D][LVD_BIT]   = periph_evt.low_voltage;
    end

    // Pending requests and fixed-priority pick, index 0 wins
    always_comb begin
        pend = '0;
        sel  = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            pend[i] = regs[SRC_REG[i]][SRC_FLAG[i]] && regs[SRC_REG[i]][SRC_EN[i]];
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel = SRC_W'(i);
            end
        end
    end

    assign global_irq_enable = regs[IDX_CTL_A][EMI_BIT];
    assign take_now = global_irq_enable && (|pend) && core_ready && !return_from_interrupt && (sp != SP_FULL);
    assign return_from_interrupt_now = return_from_interrupt && (sp != '0);
    // one vector per group or source
    assign vector_pc = PC_W'(VEC_BASE + int'(sel) * VEC_STEP);

    // Automatic clears on service; only the chosen flag and the global enable
    always_comb begin
        for (int r = 0; r < REG_CNT; r++) begin
            hw_clr[r] = 8'h00;
        end
        if (take_now) begin
            hw_clr[IDX_CTL_A][EMI_BIT] = 1'b1;
            hw_clr[SRC_REG[sel]][SRC_FLAG[sel]] = 1'b1;
        end
    end

    // Register file: write, then clear, then set, so sets are never lost
    generate
        for (genvar g = 0; g < REG_CNT; g++) begin : g_reg
            assign wr_hit[g]    = bus_wr && (reg_idx == 3'(g));
            assign sw_val[g]    = wr_hit[g] ? (writedata[7:0] & IMPL_MASK[g]) : regs[g];
            assign next_regs[g] = ((sw_val[g] & ~hw_clr[g]) | hw_set[g]) & IMPL_MASK[g];
            assign flag_rise[g] = |(next_regs[g] & ~regs[g] & FLAG_MASK[g]);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    regs[g] <= REG_RESET;
                end else begin
                    regs[g] <= next_regs[g];
                end
            end
        end
    endgenerate

    // Return-address stack, no reset needed on the storage itself
    assign top_idx  = IX_W'(sp - SP_ONE);
    assign push_idx = IX_W'(sp);
    assign stack_top = stack_mem[top_idx];

    always_ff @(posedge clk_sys) begin
        if (take_now) begin
            stack_mem[push_idx] <= fetch_pc;
        end
    end

    // Stack pointer and core-facing outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sp            <= '0;
            irq_take      <= 1'b0;
            pc_load_valid <= 1'b0;
            pc_load       <= '0;
            wake          <= 1'b0;
        end else begin
            irq_take      <= take_now;
            pc_load_valid <= take_now || return_from_interrupt_now;
            wake          <= |flag_rise;
            if (return_from_interrupt_now) begin
                sp      <= sp - SP_ONE;
                pc_load <= stack_top;
            end else if (take_now) begin
                sp      <= sp + SP_ONE;
                pc_load <= vector_pc;
            end
        end
    end

    // Checks on the controller's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_pop_req;
        return_from_interrupt && (sp != '0);
    endsequence

    sequence s_pop_done;
        pc_load_valid && !irq_take && (pc_load == $past(stack_top));
    endsequence

    a_pin1_rise_flag:
    assert property ((regs[IDX_EDGE][PIN1_SEL_LSB +: 2] == EDGE_RISE) && ext_pin_one && !pin1_q
                     |=> regs[IDX_CTL_A][PIN1_BIT])
        else $error("pin one rising edge did not set its flag");

    a_pin0_fall_flag:
    assert property ((regs[IDX_EDGE][PIN0_SEL_LSB +: 2] == EDGE_FALL) && !ext_pin_zero && pin0_q
                     |=> regs[IDX_CTL_A][PIN0_BIT])
        else $error("pin zero falling edge did not set its flag");

    a_reserved_read_zero:
    assert property (read && !waitrequest |-> readdata[31:4] == 28'h0 ||
                     (address[ADDR_W-1:2] != IDX_EDGE))
        else $error("unimplemented edge select bits read non-zero");

    a_event_sets_flag:
    assert property (periph_evt.adc && !regs[IDX_CTL_B][ADC_BIT]
                     |=> regs[IDX_CTL_B][ADC_BIT] && wake)
        else $error("converter event did not set its flag");

    a_take_needs_global:
    assert property (irq_take |-> $past(global_irq_enable) && !global_irq_enable)
        else $error("interrupt taken without global enable or enable not cleared");

    a_full_stack_block:
    assert property (sp == SP_FULL |=> !irq_take)
        else $error("interrupt acknowledged while stack full");

    a_pop_resumes:
    assert property (s_pop_req |=> s_pop_done ##0 (sp == $past(sp) - SP_ONE))
        else $error("return did not pop the saved address");

    a_group_follow:
    assert property (periph_evt.low_voltage && !regs[IDX_GRP_D][LVD_BIT]
                     |=> regs[IDX_CTL_C][GRP3_BIT] && wake)
        else $error("group flag or wake missed a member event");

    a_set_beats_clear:
    assert property (periph_evt.uart && bus_wr && (reg_idx == IDX_CTL_B)
                     |=> regs[IDX_CTL_B][UART_BIT])
        else $error("software clear swallowed a hardware event");

    a_priority_pick:
    assert property (take_now && pend[0] |=> irq_take && (pc_load == PC_W'(VEC_BASE))
                     && !regs[IDX_CTL_A][PIN0_BIT] || $past(pin0_hit))
        else $error("highest-priority source was not chosen");

    a_push_next_addr:
    assert property (take_now |=> stack_top == $past(fetch_pc))
        else $error("taken interrupt did not push the next address");

    a_group_keeps_member:
    assert property (take_now && (sel == SRC_W'(NUM_SRC - 1)) && !wr_hit[IDX_GRP_D]
                     && !periph_evt.eeprom_write && !periph_evt.low_voltage
                     |=> regs[IDX_GRP_D] == $past(regs[IDX_GRP_D]))
        else $error("group service disturbed its member flags");

    a_wake_on_touch:
    assert property (periph_evt.touch && !regs[IDX_CTL_A][TOUCH_BIT] |=> wake)
        else $error("new touch flag raised no wake pulse");

    a_latch_while_off:
    assert property (!global_irq_enable && periph_evt.tick0 |=> regs[IDX_CTL_C][TICK0_BIT])
        else $error("time base flag lost while global enable low");

    a_pin1_both_edges:
    assert property ((regs[IDX_EDGE][PIN1_SEL_LSB +: 2] == EDGE_BOTH)
                     && (ext_pin_one != pin1_q) |=> regs[IDX_CTL_A][PIN1_BIT])
        else $error("pin one edge in both-edge mode did not set its flag");

endmodule

/* File: tb/core_model.sv */
// Purpose: Behavioural core that answers the interrupt controller
// Assumes: Core is stalled, so the next-fetch address moves only on loads
// Notes:   The bench raises a return through do_return
module core_model #(
    parameter int PC_W = 13
) (
    input  wire logic            clk_sys,
    input  wire logic            reset_n,
    input  wire logic            allow,
    input  wire logic            pc_load_valid,
    input  wire logic [PC_W-1:0] pc_load,
    output logic                 core_ready,
    output logic      [PC_W-1:0] fetch_pc,
    output logic                 return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Boundary level under bench control, so register tests see no takes
    assign core_ready = allow;

    // next address after a vector or return load
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fetch_pc <= PC_W'(16'h0100);
        end else if (pc_load_valid) begin
            fetch_pc <= pc_load + PC_W'(1);
        end
    end

    initial return_from_interrupt = 1'b0;

    task automatic do_return();
        @(posedge clk_sys);
        return_from_interrupt <= 1'b1;
        @(posedge clk_sys);
        return_from_interrupt <= 1'b0;
    endtask
endmodule

/* File: tb/test_irq_controller.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: One wait state per bus access, pulses one cycle wide except the UART event held across a write
// Notes:   Vectors reckoned as base plus priority index times step
module test_irq_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctl_pkg::*;

    localparam int VB = 4;
    localparam int VS = 4;
    logic              clk_sys = 1'b0;
    logic              reset_n;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              ext_pin_zero;
    logic              ext_pin_one;
    periph_evt_s       periph_evt;
    logic              core_ready;
    logic [12:0]       fetch_pc;
    logic              return_from_interrupt;
    logic              irq_take;
    logic              pc_load_valid;
    logic [12:0]       pc_load;
    logic              wake;
    logic              allow;
    int                errors = 0;
    int                n_compared = 0;
    int                takes = 0;
    int                loads = 0;
    int                wakes = 0;
    int                cycles = 0;

    always #10 clk_sys = ~clk_sys;

    irq_controller #(.PC_W(13), .STACK_DEPTH(8), .VEC_BASE(VB), .VEC_STEP(VS)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .ext_pin_zero(ext_pin_zero),
        .ext_pin_one(ext_pin_one), .periph_evt(periph_evt), .core_ready(core_ready),
        .fetch_pc(fetch_pc), .return_from_interrupt(return_from_interrupt),
        .irq_take(irq_take), .pc_load_valid(pc_load_valid), .pc_load(pc_load),
        .wake(wake));

    core_model #(.PC_W(13)) core (
        .clk_sys(clk_sys), .reset_n(reset_n), .allow(allow),
        .pc_load_valid(pc_load_valid), .pc_load(pc_load), .core_ready(core_ready),
        .fetch_pc(fetch_pc), .return_from_interrupt(return_from_interrupt));

    // Pulse counters and hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (irq_take === 1'b1) takes++;
        if (wake === 1'b1) wakes++;
        if (pc_load_valid === 1'b1) loads++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Avalon access: hold until waitrequest sampled low, then release
    task automatic bus(input logic wr, input int a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        address   <= ADDR_W'(a);
        writedata <= {24'h0, d};
        read      <= ~wr;
        write     <= wr;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx * 4, d, q);
    endtask

    task automatic chk(input int idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx * 4, 8'h00, q);
        check({24'h0, q}, {24'h0, exp});
    endtask

    task automatic wait_takes(input int n);
        for (int k = 0; k < 30 && takes < n; k++) @(posedge clk_sys);
        check(takes, n);
    endtask

    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset values, reserved bits and a misaligned access
    task automatic reg_table();
        logic [7:0] q;
        for (int i = 0; i < REG_CNT; i++) chk(i, REG_RESET);
        for (int i = 0; i < REG_CNT; i++) wr(i, 8'hFF);
        for (int i = 0; i < REG_CNT; i++) chk(i, IMPL_MASK[i]);
        for (int i = 0; i < REG_CNT; i++) wr(i, 8'h00);
        bus(1'b1, 5, 8'hFF, q);
        bus(1'b0, 5, 8'h00, q);
        check({24'h0, q}, 32'h0);
        chk(IDX_CTL_A, 8'h00);
    endtask

    // Every edge mode on both pins, rising then falling
    task automatic edges();
        logic [7:0] b;
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                b = 8'h01 << (PIN0_BIT + p);
                wr(IDX_EDGE, 8'(m << (2 * p)));
                wr(IDX_CTL_A, 8'h00);
                if (p == 0) ext_pin_zero <= 1'b1; else ext_pin_one <= 1'b1;
                chk(IDX_CTL_A, (m == 1 || m == 3) ? b : 8'h00);
                wr(IDX_CTL_A, 8'h00);
                if (p == 0) ext_pin_zero <= 1'b0; else ext_pin_one <= 1'b0;
                chk(IDX_CTL_A, (m == 2 || m == 3) ? b : 8'h00);
            end
        end
        wr(IDX_EDGE, 8'h00);
        wr(IDX_CTL_A, 8'h00);
    endtask

    // Grouped low-voltage event, held off by global enable, then served
    task automatic group_take();
        int w0;
        int t0;
        w0 = wakes;
        t0 = takes;
        @(posedge clk_sys);
        periph_evt.low_voltage <= 1'b1;
        @(posedge clk_sys);
        periph_evt <= '0;
        repeat (3) @(posedge clk_sys);
        check(wakes, w0 + 1);
        chk(IDX_GRP_D, 8'h10);
        chk(IDX_CTL_C, 8'h80);
        wr(IDX_GRP_D, 8'h11);
        wr(IDX_CTL_C, 8'h88);
        allow <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check(takes, t0);
        wr(IDX_CTL_A, 8'h01);
        wait_takes(t0 + 1);
        check(32'(pc_load), VB + 10 * VS);
        chk(IDX_CTL_A, 8'h00);
        chk(IDX_CTL_C, 8'h08);
        chk(IDX_GRP_D, 8'h11);
        core.do_return();
        repeat (2) @(posedge clk_sys);
        check(32'(pc_load), 32'h100);
        wr(IDX_GRP_D, 8'h00);
        wr(IDX_CTL_C, 8'h00);
    endtask

    // Three enabled sources at once plus one disabled
    task automatic priority_order();
        int t0;
        int idx[3] = '{2, 3, 6};
        t0 = takes;
        wr(IDX_CTL_A, 8'h08);
        wr(IDX_CTL_B, 8'h09);
        @(posedge clk_sys);
        periph_evt.touch <= 1'b1;
        periph_evt.uart  <= 1'b1;
        periph_evt.adc   <= 1'b1;
        periph_evt.tick0 <= 1'b1;
        @(posedge clk_sys);
        periph_evt <= '0;
        chk(IDX_CTL_C, 8'h20);
        wr(IDX_CTL_A, 8'h49);
        for (int i = 0; i < 3; i++) begin
            if (i > 0) wr(IDX_CTL_A, 8'h09);
            wait_takes(t0 + i + 1);
            check(32'(pc_load), VB + idx[i] * VS);
            core.do_return();
        end
        chk(IDX_CTL_A, 8'h08);
        chk(IDX_CTL_B, 8'h09);
        wr(IDX_CTL_A, 8'h09);
        repeat (10) @(posedge clk_sys);
        check(takes, t0 + 3);
        wr(IDX_CTL_A, 8'h08);
        wr(IDX_CTL_B, 8'h00);
        wr(IDX_CTL_C, 8'h00);
    endtask

    // Group members, a clear meeting a UART event, both pins at once
    task automatic members();
        int t0;
        int l0;
        t0 = takes;
        l0 = loads;
        @(posedge clk_sys);
        periph_evt.ctimer0_match_a        <= 1'b1;
        periph_evt.stdtimer_match_p       <= 1'b1;
        periph_evt.ctimer1_match_a        <= 1'b1;
        periph_evt.serial_iface           <= 1'b1;
        periph_evt.periodic_timer_match_p <= 1'b1;
        periph_evt.eeprom_write           <= 1'b1;
        @(posedge clk_sys);
        periph_evt <= '0;
        chk(IDX_GRP_A, 8'h20);
        chk(IDX_GRP_B, 8'h60);
        chk(IDX_GRP_C, 8'h50);
        chk(IDX_GRP_D, 8'h20);
        chk(IDX_CTL_B, 8'h60);
        chk(IDX_CTL_C, 8'h90);
        wr(IDX_CTL_B, 8'h00);
        wr(IDX_CTL_C, 8'h00);
        @(posedge clk_sys);
        periph_evt.ctimer0_match_p        <= 1'b1;
        periph_evt.stdtimer_match_a       <= 1'b1;
        periph_evt.ctimer1_match_p        <= 1'b1;
        periph_evt.periodic_timer_match_a <= 1'b1;
        periph_evt.low_voltage            <= 1'b1;
        @(posedge clk_sys);
        periph_evt <= '0;
        chk(IDX_GRP_A, 8'h30);
        chk(IDX_GRP_B, 8'hF0);
        chk(IDX_GRP_C, 8'h70);
        chk(IDX_GRP_D, 8'h30);
        chk(IDX_CTL_B, 8'h60);
        chk(IDX_CTL_C, 8'h90);
        for (int i = IDX_GRP_A; i < REG_CNT; i++) wr(i, 8'h00);
        wr(IDX_CTL_C, 8'h00);
        // UART event held across the write that clears its register
        @(posedge clk_sys);
        periph_evt.uart <= 1'b1;
        wr(IDX_CTL_B, 8'h00);
        periph_evt <= '0;
        chk(IDX_CTL_B, 8'h10);
        wr(IDX_CTL_B, 8'h00);
        wr(IDX_EDGE, 8'h05);
        wr(IDX_CTL_A, 8'h07);
        ext_pin_zero <= 1'b1;
        ext_pin_one  <= 1'b1;
        wait_takes(t0 + 1);
        check(32'(pc_load), VB);
        chk(IDX_CTL_A, 8'h26);
        core.do_return();
        wr(IDX_CTL_A, 8'h27);
        wait_takes(t0 + 2);
        check(32'(pc_load), VB + VS);
        core.do_return();
        repeat (2) @(posedge clk_sys);
        check(loads, l0 + 4);
        ext_pin_zero <= 1'b0;
        ext_pin_one  <= 1'b0;
        wr(IDX_EDGE, 8'h00);
        wr(IDX_CTL_A, 8'h00);
    endtask

    // Nest eight deep, ninth waits for a pop
    task automatic stack_full();
        int t0;
        t0 = takes;
        for (int i = 0; i < 8; i++) begin
            wr(IDX_CTL_A, 8'h49);
            wait_takes(t0 + i + 1);
        end
        wr(IDX_CTL_A, 8'h49);
        repeat (10) @(posedge clk_sys);
        check(takes, t0 + 8);
        core.do_return();
        wait_takes(t0 + 9);
        check(32'(pc_load), VB + 2 * VS);
    endtask

    initial begin
        reset_n      = 1'b0;
        address      = '0;
        read         = 1'b0;
        write        = 1'b0;
        writedata    = '0;
        ext_pin_zero = 1'b0;
        ext_pin_one  = 1'b0;
        periph_evt   = '0;
        allow        = 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_table();
        edges();
        group_take();
        priority_order();
        members();
        stack_full();
        conclude();
    end
endmodule
